/* File: src/mrg_rate_gate.sv */
// Speed, gating and aperture setup with validation, reached over AHB-Lite.
`timescale 1ns/1ps
// Notes on behaviour
// - Entering fast speed turns averaging, gain, second_gain_correction, relative off; math goes plain.
// - Leaving fast for normal or double restores couplings saved on entry.
// - Speeds are normal 20/s, double 40/s and fast about 3500/s.
// - Selecting normal or double forces the trigger repeat count to one.
// - Fast with averaging detector reads at one over the aperture.
// - Speed resets to normal; status shows the present speed.
// - A speed value outside the three choices posts error -224.
// - Sample rate read returns the sensor rate and changes nothing.
// - Per gate, once launches auto gating; on and off set perpetual gating.
// - Auto gating and marker writes need internal or external trigger, else -221.
// - A failed auto once run posts -221 with the auto once qualifier.
// - On or once while list mode is enabled posts -221 with list qualifier.
// - Perpetual gating resets off; status shows one bit per gate.
// - Markers take 0.0 to 99.9 percent; sum above 99.9 posts -222.
// - Gate offset spans -1 to 1 s in 50 ns steps, resets to zero.
// - Offset or length write with perpetual gating on posts -221.
// - Gate length 0 to 1 s in 50 ns; gate one resets 100 us.
// - Averaging detector refuses all gating, marker, offset and length writes.
// - Aperture 20 us to 200 ms in 100 ns, resets 50 ms, else -222.
// - Writing an aperture turns automatic aperture off.
// - Below 300 MHz minimum is 50 us; a drop raises shorter apertures, -221.
// - Aperture write refused when detector is peak or speed not normal.
// - Automatic aperture follows speed: 50 ms, 25 ms or 2 ms.
`include "mrg_regs.svh"

module mrg_rate_gate
   import mrg_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [31:0] sample_rate,
   input  wire logic        auto_gate_fail,
   output logic      [3:0]  auto_gate_start,
   output logic      [3:0]  perpetual_gate
);

   // ****************************************************************
   // Helper functions
   // ****************************************************************

   // Posts one error code with its qualifier and counts it.
   function automatic mrg_state_t post_err(input mrg_state_t st,
                                           input logic [15:0] code,
                                           input mrg_qual_t qual);
      mrg_state_t r;
      r = st;
      r.err_code  = code;
      r.err_qual  = qual;
      r.err_valid = 1'b1;
      r.err_cnt   = st.err_cnt + 8'h01;
      return r;
   endfunction

   // Aperture that automatic selection picks for a speed.
   function automatic logic [20:0] auto_aper(input mrg_speed_t spd);
      case (spd)
         MRG_SPD_DOUBLE: auto_aper = `MRG_APER_DBL;
         MRG_SPD_FAST:   auto_aper = `MRG_APER_FAST;
         default:        auto_aper = `MRG_APER_RST;
      endcase
   endfunction

   // Register read view of a state.
   function automatic logic [31:0] rd_mux(input mrg_state_t st, input logic [7:0] a,
                                          input logic [31:0] sample_rate_query, input logic [31:0] rate);
      logic [1:0] g;
      g = a[5:4];
      rd_mux = 32'h00000000;
      if (a[7:6] == 2'h1)
      begin
         case (a[3:0])
            4'h0:    rd_mux = {{6{st.offs[g][25]}}, st.offs[g]};
            4'h4:    rd_mux = {7'h00, st.len[g]};
            4'h8:    rd_mux = {22'h000000, st.lead[g]};
            4'hC:    rd_mux = {22'h000000, st.trail[g]};
            default: rd_mux = 32'h00000000;
         endcase
      end
      else
      begin
         case (a)
            `MRG_OFS_ARG:     rd_mux = st.arg;
            `MRG_OFS_ERR:     rd_mux = {1'b0, st.err_valid, 3'h0, st.err_cnt,
                                        st.err_qual, st.err_code};
            `MRG_OFS_STAT:    rd_mux = {23'h000000, st.perp, 2'h0, st.aper_auto, st.speed};
            `MRG_OFS_ENV:     rd_mux = {27'h0000000, st.env};
            `MRG_OFS_APER:    rd_mux = {11'h000, st.aper};
            `MRG_OFS_RATE:    rd_mux = rate;
            `MRG_OFS_SAMPLE_RATE_QUERY:   rd_mux = sample_rate_query;
            `MRG_OFS_COUPLE:  rd_mux = {12'h000, st.couple};
            `MRG_OFS_TRIGCNT: rd_mux = {16'h0000, st.trig_cnt};
            default:          rd_mux = 32'h00000000;
         endcase
      end
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   mrg_state_t s_q;
   mrg_state_t s_d;

   // Every transfer completes at once with an OKAY answer.
   assign hreadyout       = 1'b1;
   assign hresp           = 1'b0;
   assign hrdata          = s_q.rdata;
   assign auto_gate_start = s_q.start;
   assign perpetual_gate  = s_q.perp;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb
   begin
      logic              cmd;
      logic              wr;
      mrg_op_t           op;
      logic [1:0]        g;
      logic signed [31:0] a;
      logic              avg;
      logic              trig_ok;
      logic              list_on;
      logic [31:0]       rate;
      logic [31:0]       aper_min;
      logic [19:0]       forced;
      s_d      = s_q;
      wr       = s_q.ap_sel & s_q.ap_write;
      cmd      = wr & (s_q.ap_addr == `MRG_OFS_CMD);
      op       = mrg_op_t'(hwdata[`MRG_CMD_OP_LSB +: 4]);
      g        = hwdata[`MRG_CMD_GATE_LSB +: 2];
      a        = $signed(s_q.arg);
      avg      = s_q.env[`MRG_ENV_DET_AVG];
      trig_ok  = (s_q.env[`MRG_ENV_TRIG_LSB +: 2] < 2'h2);
      list_on  = s_q.env[`MRG_ENV_LIST];
      aper_min = s_q.env[`MRG_ENV_FREQ_LOW] ? {11'h000, `MRG_APER_MIN_LOW}
                                            : {11'h000, `MRG_APER_MIN};
      forced   = {4'hF, 16'h0000}; // math plain on, all gain, relative, averaging off
      rate     = 32'h00000000;
      s_d.start = 4'h0;

      // Plain register writes; the error clear goes first so a new error wins.
      if (wr)
      begin
         case (s_q.ap_addr)
            `MRG_OFS_ARG:     s_d.arg = hwdata;
            `MRG_OFS_ENV:     s_d.env = hwdata[4:0];
            `MRG_OFS_COUPLE:  s_d.couple = hwdata[19:0];
            `MRG_OFS_TRIGCNT: s_d.trig_cnt = hwdata[15:0];
            `MRG_OFS_ERR:
            begin
               if (hwdata[`MRG_ERR_CLEAR])
               begin
                  s_d.err_valid = 1'b0;
               end
            end
            default: ;
         endcase
      end

      // Events wait here until a cycle without a command serves them.
      s_d.freq_low_seen = s_q.env[`MRG_ENV_FREQ_LOW];
      if (s_q.env[`MRG_ENV_FREQ_LOW] & ~s_q.freq_low_seen)
      begin
         s_d.pend_freq = 1'b1;
      end
      if (auto_gate_fail)
      begin
         s_d.pend_fail = 1'b1;
      end

      if (cmd)
      begin
         case (op)
            MRG_OP_SPEED:
            begin
               if ((a < 0) || (a > 2))
               begin
                  s_d = post_err(s_d, `MRG_ERR_ILLEGAL, MRG_Q_NONE);
               end
               else if (a == 2)
               begin
                  if (s_q.speed != MRG_SPD_FAST)
                  begin
                     s_d.saved  = s_q.couple;
                     s_d.couple = forced;
                  end
                  s_d.speed = MRG_SPD_FAST;
               end
               else
               begin
                  if (s_q.speed == MRG_SPD_FAST)
                  begin
                     s_d.couple = s_q.saved;
                  end
                  s_d.trig_cnt = `MRG_TRIGCNT_RST;
                  s_d.speed    = mrg_speed_t'(a[1:0]);
               end
            end
            MRG_OP_GATE_AUTO:
            begin
               if (avg)
               begin
                  s_d = post_err(s_d, `MRG_ERR_CONFLICT, MRG_Q_NONE);
               end
               else if (!trig_ok)
               begin
                  s_d = post_err(s_d, `MRG_ERR_CONFLICT, MRG_Q_NONE);
               end
               else if ((a < 0) || (a > 2))
               begin
                  s_d = post_err(s_d, `MRG_ERR_ILLEGAL, MRG_Q_NONE);
               end
               else if (list_on && (a != 0))
               begin
                  s_d = post_err(s_d, `MRG_ERR_CONFLICT, MRG_Q_LIST_ENABLED);
               end
               else if (a == 2)
               begin
                  s_d.start[g] = 1'b1;
               end
               else
               begin
                  s_d.perp[g] = a[0];
               end
            end
            MRG_OP_MARK_LEAD, MRG_OP_MARK_TRAIL:
            begin
               if (avg)
               begin
                  s_d = post_err(s_d, `MRG_ERR_CONFLICT, MRG_Q_NONE);
               end
               else if (!trig_ok)
               begin
                  s_d = post_err(s_d, `MRG_ERR_CONFLICT, MRG_Q_NONE);
               end
               else if ((a < 0) || (a > $signed(`MRG_MARK_MAX)) ||
                        ((a + $signed({22'h000000, (op == MRG_OP_MARK_LEAD) ?
                          s_q.trail[g] : s_q.lead[g]})) > $signed(`MRG_MARK_MAX)))
               begin
                  s_d = post_err(s_d, `MRG_ERR_RANGE, MRG_Q_NONE);
               end
               else if (op == MRG_OP_MARK_LEAD)
               begin
                  s_d.lead[g] = a[9:0];
               end
               else
               begin
                  s_d.trail[g] = a[9:0];
               end
            end
            MRG_OP_GATE_OFFSET, MRG_OP_GATE_LENGTH:
            begin
               if (avg)
               begin
                  s_d = post_err(s_d, `MRG_ERR_CONFLICT, MRG_Q_NONE);
               end
               else if (s_q.perp[g])
               begin
                  s_d = post_err(s_d, `MRG_ERR_CONFLICT, MRG_Q_NONE);
               end
               else if (a > $signed(`MRG_TIME_MAX))
               begin
                  s_d = post_err(s_d, `MRG_ERR_RANGE, MRG_Q_NONE);
                  s_d.offs[g] = (op == MRG_OP_GATE_OFFSET) ? 26'(`MRG_TIME_MAX) : s_q.offs[g];
                  s_d.len[g]  = (op == MRG_OP_GATE_LENGTH) ? 25'(`MRG_TIME_MAX) : s_q.len[g];
               end
               else if ((op == MRG_OP_GATE_OFFSET) && (a < -$signed(`MRG_TIME_MAX)))
               begin
                  s_d = post_err(s_d, `MRG_ERR_RANGE, MRG_Q_NONE);
                  s_d.offs[g] = 26'(-$signed(`MRG_TIME_MAX));
               end
               else if ((op == MRG_OP_GATE_LENGTH) && (a < 0))
               begin
                  s_d = post_err(s_d, `MRG_ERR_RANGE, MRG_Q_NONE);
                  s_d.len[g] = 25'h0000000;
               end
               else if (op == MRG_OP_GATE_OFFSET)
               begin
                  s_d.offs[g] = a[25:0];
               end
               else
               begin
                  s_d.len[g] = a[24:0];
               end
            end
            MRG_OP_APERTURE:
            begin
               if (!avg || (s_q.speed != MRG_SPD_NORMAL))
               begin
                  s_d = post_err(s_d, `MRG_ERR_CONFLICT, MRG_Q_NONE);
               end
               else if ((a < $signed(aper_min)) ||
                        (a > $signed({11'h000, `MRG_APER_MAX})))
               begin
                  s_d = post_err(s_d, `MRG_ERR_RANGE, MRG_Q_NONE);
               end
               else
               begin
                  s_d.aper      = a[20:0];
                  s_d.aper_auto = 1'b0;
               end
            end
            MRG_OP_APER_AUTO:
            begin
               if (!avg && a[0])
               begin
                  s_d = post_err(s_d, `MRG_ERR_CONFLICT, MRG_Q_NONE);
               end
               else
               begin
                  s_d.aper_auto = a[0];
               end
            end
            default: s_d = post_err(s_d, `MRG_ERR_ILLEGAL, MRG_Q_NONE);
         endcase
      end
      else if (s_q.pend_fail)
      begin
         s_d.pend_fail = auto_gate_fail;
         s_d = post_err(s_d, `MRG_ERR_CONFLICT, MRG_Q_AUTO_ONCE_FAILED);
      end
      else if (s_q.pend_freq)
      begin
         s_d.pend_freq = s_q.env[`MRG_ENV_FREQ_LOW] & ~s_q.freq_low_seen;
         if (s_q.aper < `MRG_APER_MIN_LOW)
         begin
            s_d.aper = `MRG_APER_MIN_LOW;
            s_d = post_err(s_d, `MRG_ERR_CONFLICT, MRG_Q_APER_TOO_SMALL);
         end
      end

      // Automatic aperture tracks the speed.
      if (s_d.aper_auto)
      begin
         s_d.aper = auto_aper(s_d.speed);
      end

      // Reading rate of the selected speed.
      case (s_d.speed)
         MRG_SPD_DOUBLE: rate = `MRG_RATE_DBL;
         MRG_SPD_FAST:   rate = s_d.env[`MRG_ENV_DET_AVG] ?
                                `MRG_APER_TICKS_S / {11'h000, s_d.aper}
                                : `MRG_RATE_FAST;
         default:        rate = `MRG_RATE_PEAK_CAPABLE_DETECTOR;
      endcase

      // Address phase capture; read data reflects this cycle's updates.
      s_d.ap_sel   = hsel & hready & htrans[1];
      s_d.ap_write = hwrite;
      s_d.ap_addr  = haddr[7:0];
      if (hsel & hready & htrans[1] & ~hwrite)
      begin
         s_d.rdata = rd_mux(s_d, haddr[7:0], sample_rate, rate);
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s_q           <= '0;
         s_q.len[0]    <= `MRG_LEN_RST;
         s_q.aper      <= `MRG_APER_RST;
         s_q.aper_auto <= 1'b1;
         s_q.trig_cnt  <= `MRG_TRIGCNT_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

endmodule

/* File: src/mrg_regs.svh */
// Register offsets, field positions, reset values and limits of the rate and gate setup block.
`ifndef MRG_REGS_SVH
`define MRG_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define MRG_OFS_CMD      8'h00
`define MRG_OFS_ARG      8'h04
`define MRG_OFS_ERR      8'h08
`define MRG_OFS_STAT     8'h0C
`define MRG_OFS_ENV      8'h10
`define MRG_OFS_APER     8'h14
`define MRG_OFS_RATE     8'h18
`define MRG_OFS_SAMPLE_RATE_QUERY    8'h1C
`define MRG_OFS_COUPLE   8'h20
`define MRG_OFS_TRIGCNT  8'h24
`define MRG_OFS_GATE     8'h40

// ****************************************************************
// Field positions
// ****************************************************************
`define MRG_CMD_OP_LSB   0
`define MRG_CMD_GATE_LSB 4
`define MRG_ENV_DET_AVG  0
`define MRG_ENV_TRIG_LSB 1
`define MRG_ENV_LIST     3
`define MRG_ENV_FREQ_LOW 4
`define MRG_ERR_CLEAR    31
`define MRG_ERR_VALID    30

// ****************************************************************
// Error codes, sixteen bit two's complement
// ****************************************************************
`define MRG_ERR_CONFLICT 16'hFF23
`define MRG_ERR_RANGE    16'hFF22
`define MRG_ERR_ILLEGAL  16'hFF20

// ****************************************************************
// Reset values and limits
// ****************************************************************
`define MRG_LEN_RST      25'h00007D0
`define MRG_APER_RST     21'h07A120
`define MRG_APER_DBL     21'h03D090
`define MRG_APER_FAST    21'h004E20
`define MRG_APER_MIN     21'h0000C8
`define MRG_APER_MIN_LOW 21'h0001F4
`define MRG_APER_MAX     21'h1E8480
`define MRG_TIME_MAX     32'h01312D00
`define MRG_MARK_MAX     32'h000003E7
`define MRG_RATE_PEAK_CAPABLE_DETECTOR    32'h00000014
`define MRG_RATE_DBL     32'h00000028
`define MRG_RATE_FAST    32'h00000DAC
`define MRG_APER_TICKS_S 32'h00989680
`define MRG_TRIGCNT_RST  16'h0001

`endif

/* File: src/mrg_pkg.sv */
// Types shared by the rate and gate setup block.
package mrg_pkg;

   // Speed selections as they appear in the argument and status registers.
   typedef enum logic [1:0] {
      MRG_SPD_NORMAL,
      MRG_SPD_DOUBLE,
      MRG_SPD_FAST
   } mrg_speed_t;

   // Command opcodes carried in the low bits of the command register.
   typedef enum logic [3:0] {
      MRG_OP_NONE,
      MRG_OP_SPEED,
      MRG_OP_GATE_AUTO,
      MRG_OP_MARK_LEAD,
      MRG_OP_MARK_TRAIL,
      MRG_OP_GATE_OFFSET,
      MRG_OP_GATE_LENGTH,
      MRG_OP_APERTURE,
      MRG_OP_APER_AUTO
   } mrg_op_t;

   // Qualifiers that refine a settings conflict.
   typedef enum logic [2:0] {
      MRG_Q_NONE,
      MRG_Q_AUTO_ONCE_FAILED,
      MRG_Q_LIST_ENABLED,
      MRG_Q_APER_TOO_SMALL
   } mrg_qual_t;

   // Whole state of the block.
   typedef struct packed {
      mrg_speed_t       speed;
      logic             aper_auto;
      logic [20:0]      aper;
      logic [3:0]       perp;
      logic [3:0][9:0]  lead;
      logic [3:0][9:0]  trail;
      logic [3:0][25:0] offs;
      logic [3:0][24:0] len;
      logic [19:0]      couple;
      logic [19:0]      saved;
      logic [15:0]      trig_cnt;
      logic [4:0]       env;
      logic             freq_low_seen;
      logic [31:0]      arg;
      logic [15:0]      err_code;
      mrg_qual_t        err_qual;
      logic             err_valid;
      logic [7:0]       err_cnt;
      logic             pend_freq;
      logic             pend_fail;
      logic [3:0]       start;
      logic             ap_sel;
      logic             ap_write;
      logic [7:0]       ap_addr;
      logic [31:0]      rdata;
   } mrg_state_t;

endpackage

/* File: verif/mrg_rate_gate_sva.sv */
// Checker of gating effects at the ports of the rate and gate setup block.
`timescale 1ns/1ps
module mrg_rate_gate_sva
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] sample_rate,
   input wire logic [3:0]  auto_gate_start,
   input wire logic [3:0]  perpetual_gate
);
   // ****************************************************************
   // Bus tracking
   // ****************************************************************
   logic [4:0]  dp_q;
   logic        done_q;
   logic [31:0] cmd_q;
   logic [31:0] arg_q;
   logic [31:0] env_q;
   wire         ap = hsel && hready && htrans[1];
   wire         gate_cmd = done_q && cmd_q[3:0] == 4'h2;
   wire  [3:0]  gbit = 4'h1 << cmd_q[5:4];
   // Follows the data phases of command, argument, environment and sample rate reads.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         {dp_q, done_q, cmd_q, arg_q, env_q} <= '0;
      end
      else
      begin
         dp_q <= {ap && !hwrite && haddr[7:0] == 8'h1C, ap && hwrite && haddr[7:0] == 8'h10,
                  ap && hwrite && haddr[7:0] == 8'h04, ap && hwrite && haddr[7:0] == 8'h00,
                  1'b0};
         done_q <= dp_q[1];
         cmd_q <= dp_q[1] ? hwdata : cmd_q;
         arg_q <= dp_q[2] ? hwdata : arg_q;
         env_q <= dp_q[3] ? hwdata : env_q;
      end
   end
   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_gate_cmd;
      gate_cmd;
   endsequence
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready and okay");
   a_perp_reset: assert property ($rose(hresetn) |-> perpetual_gate == 4'h0)
      else $error("perpetual gating not off after reset");
   a_perp_cause: assert property (!$stable(perpetual_gate) |-> gate_cmd && arg_q < 32'h2
      && (perpetual_gate ^ $past(perpetual_gate)) == gbit && perpetual_gate[cmd_q[5:4]] == arg_q[0])
      else $error("perpetual gating changed without its command");
   a_start_cause: assert property (|auto_gate_start |-> gate_cmd && arg_q == 32'h2
      && auto_gate_start == gbit && $stable(perpetual_gate))
      else $error("gating run started without its command");
   a_start_pulse: assert property (|auto_gate_start |=> auto_gate_start == 4'h0)
      else $error("gating start longer than one cycle");
   a_gate_refused: assert property (s_gate_cmd ##0 (env_q[0] || env_q[2]
      || (env_q[3] && arg_q != 32'h0)) |-> $stable(perpetual_gate) && auto_gate_start == 4'h0)
      else $error("refused gating command took effect");
   a_off_clears: assert property (s_gate_cmd ##0 (arg_q == 32'h0 && !env_q[0] && !env_q[2])
      |-> (perpetual_gate & gbit) == 4'h0)
      else $error("gating off left the gate on");
   a_rate_read: assert property (dp_q[4] |-> hrdata == $past(sample_rate))
      else $error("sample rate read differs from sensor rate");
endmodule

bind mrg_rate_gate mrg_rate_gate_sva i_mrg_rate_gate_sva (.*);

/* File: verif/mrg_sensor_model.sv */
// Sensor side model: a moving sampling rate and the outcome of automatic gating runs.
`timescale 1ns/1ps
module mrg_sensor_model
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic [3:0]  auto_gate_start,
   input  wire logic        fail_en,
   input  wire logic [3:0]  fail_dly,
   output logic      [31:0] sample_rate,
   output logic             auto_gate_fail
);
   logic [4:0] cnt_q;
   // Rate moves every cycle so a stale read shows; a run fails after a set delay when asked.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         {sample_rate, cnt_q, auto_gate_fail} <= {32'h00989680, 6'h00};
      end
      else
      begin
         sample_rate <= {sample_rate[30:0], sample_rate[31] ^ sample_rate[21]} ^ 32'h1;
         cnt_q <= (|auto_gate_start && fail_en) ? {1'b1, fail_dly}
                  : {cnt_q[4] && |cnt_q[3:0], cnt_q[3:0] - 4'h1};
         auto_gate_fail <= cnt_q == 5'h10;
      end
   end
endmodule

/* File: verif/mrg_rate_gate_tb.sv */
// Self-checking bench of the rate and gate setup block.
`timescale 1ns/1ps
`include "mrg_regs.svh"
module mrg_rate_gate_tb;
   import mrg_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, auto_gate_fail, fail_en;
   logic [1:0]  htrans, g;
   logic [2:0]  hsize;
   logic [3:0]  auto_gate_start, perpetual_gate, fail_dly;
   logic [19:0] c;
   logic [31:0] haddr, hwdata, hrdata, sample_rate, r, seed;
   int          n_fail, n_checks, t;
   mrg_rate_gate i_mrg_rate_gate (.hready(hreadyout), .*);
   mrg_sensor_model i_mrg_sensor_model (.*);
   // Expected error word: valid, qualifier and code.
   function automatic logic [19:0] ex(input mrg_qual_t q, input logic [15:0] code);
      return {1'b1, q, code};
   endfunction
   // One single AHB-Lite transfer, entered just after a rising edge.
   task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
      {hsel, htrans, hwrite, haddr} <= {3'h6, w, 24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      {hsel, htrans, hwdata} <= {3'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         $display("BAD %s expected %h seen %h", n, exp, seen);
         n_fail++;
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string n);
      xf(1'b0, a, 32'h0);
      chk(n, r, exp);
   endtask
   task automatic cmd(input logic [3:0] op, input logic [1:0] gt, input logic [31:0] arg);
      xf(1'b1, `MRG_OFS_ARG, arg);
      xf(1'b1, `MRG_OFS_CMD, {26'h0, gt, op});
   endtask
   // Checks and clears the error word; zero expects no error.
   task automatic er(input logic [19:0] x);
      xf(1'b0, `MRG_OFS_ERR, 32'h0);
      chk("err", {12'h0, r[30], x[19] ? r[18:0] : 19'h0}, {12'h0, x});
      xf(1'b1, `MRG_OFS_ERR, 32'h80000000);
   endtask
   task end_of_test;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ****************************************************************
   // Clock, watchdog and main sequence
   // ****************************************************************
   initial
   begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   // Ends a hung run as a failure.
   initial
   begin
      #800000;
      n_fail++;
      end_of_test;
   end
   initial
   begin
      {hresetn, hsel, hwrite, fail_en, htrans, hsize, fail_dly} = {6'h00, 3'h2, 4'h3};
      {haddr, hwdata, n_fail, n_checks, seed} = {64'h0, 64'h0, 32'h130B5813};
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      rc(`MRG_OFS_STAT, 32'h4, "stat");
      rc(`MRG_OFS_APER, {11'h0, `MRG_APER_RST}, "aper");
      rc(8'h44, {7'h0, `MRG_LEN_RST}, "len");
      rc(8'h54, 32'h0, "len");
      rc(8'h40, 32'h0, "offs");
      xf(1'b0, `MRG_OFS_SAMPLE_RATE_QUERY, 32'h0);
      rc(`MRG_OFS_RATE, `MRG_RATE_PEAK_CAPABLE_DETECTOR, "rate");
      for (int i = 0; i < 3; i++)
      begin
         c = 20'($random(seed));
         xf(1'b1, `MRG_OFS_COUPLE, {12'h0, c});
         xf(1'b1, `MRG_OFS_TRIGCNT, 32'h5);
         cmd(4'h1, 2'h0, 32'h2);
         rc(`MRG_OFS_COUPLE, 32'hF0000, "couple");
         rc(`MRG_OFS_RATE, `MRG_RATE_FAST, "rate");
         rc(`MRG_OFS_APER, {11'h0, `MRG_APER_FAST}, "aper");
         cmd(4'h1, 2'h0, i % 2);
         rc(`MRG_OFS_COUPLE, {12'h0, c}, "couple");
         rc(`MRG_OFS_TRIGCNT, 32'h1, "trigcnt");
         rc(`MRG_OFS_RATE, i % 2 ? `MRG_RATE_DBL : `MRG_RATE_PEAK_CAPABLE_DETECTOR, "rate");
         rc(`MRG_OFS_APER, {11'h0, i % 2 ? `MRG_APER_DBL : `MRG_APER_RST}, "aper");
      end
      cmd(4'h1, 2'h0, 32'h3);
      er(ex(MRG_Q_NONE, `MRG_ERR_ILLEGAL));
      rc(`MRG_OFS_STAT, 32'h4, "stat");
      xf(1'b1, `MRG_OFS_ENV, 32'h1);
      cmd(4'h7, 2'h0, 32'd199);
      er(ex(MRG_Q_NONE, `MRG_ERR_RANGE));
      rc(`MRG_OFS_APER, {11'h0, `MRG_APER_RST}, "aper");
      cmd(4'h7, 2'h0, 32'd200);
      er(20'h0);
      rc(`MRG_OFS_APER, 32'd200, "aper");
      rc(`MRG_OFS_STAT, 32'h0, "stat");
      cmd(4'h1, 2'h0, 32'h2);
      rc(`MRG_OFS_RATE, `MRG_APER_TICKS_S / 32'd200, "rate");
      cmd(4'h7, 2'h0, 32'd300);
      er(ex(MRG_Q_NONE, `MRG_ERR_CONFLICT));
      cmd(4'h1, 2'h0, 32'h0);
      xf(1'b1, `MRG_OFS_ENV, 32'h11);
      @(posedge hclk); // The event is served a cycle later.
      er(ex(MRG_Q_APER_TOO_SMALL, `MRG_ERR_CONFLICT));
      rc(`MRG_OFS_APER, {11'h0, `MRG_APER_MIN_LOW}, "aper");
      xf(1'b1, `MRG_OFS_ENV, 32'h0);
      cmd(4'h7, 2'h0, 32'd1000);
      er(ex(MRG_Q_NONE, `MRG_ERR_CONFLICT));
      g = 2'($random(seed));
      cmd(4'h2, g, 32'h1);
      rc(`MRG_OFS_STAT, {23'h0, 4'h1 << g, 5'h0}, "stat");
      cmd(4'h5, g, 32'd100);
      er(ex(MRG_Q_NONE, `MRG_ERR_CONFLICT));
      cmd(4'h6, g, 32'd100);
      er(ex(MRG_Q_NONE, `MRG_ERR_CONFLICT));
      cmd(4'h2, g, 32'h0);
      fail_en <= 1'b1;
      cmd(4'h2, g, 32'h2);
      for (t = 0; t < 40 && auto_gate_fail !== 1'b1; t++) @(posedge hclk);
      er(ex(MRG_Q_AUTO_ONCE_FAILED, `MRG_ERR_CONFLICT));
      for (int i = 0; i < 3; i++)
      begin
         xf(1'b1, `MRG_OFS_ENV, i == 0 ? 32'h8 : i == 1 ? 32'h4 : 32'h1);
         cmd(4'h2, g, 32'h1);
         er(ex(i == 0 ? MRG_Q_LIST_ENABLED : MRG_Q_NONE, `MRG_ERR_CONFLICT));
         rc(`MRG_OFS_STAT, 32'h0, "stat");
      end
      cmd(4'h3, g, 32'd5);
      er(ex(MRG_Q_NONE, `MRG_ERR_CONFLICT));
      xf(1'b1, `MRG_OFS_ENV, 32'h0);
      cmd(4'h3, g, 32'd600);
      cmd(4'h4, g, 32'd400);
      er(ex(MRG_Q_NONE, `MRG_ERR_RANGE));
      cmd(4'h4, g, 32'd399);
      rc({2'h1, g, 4'hC}, 32'd399, "trail");
      cmd(4'h5, g, -32'sd20000001);
      er(ex(MRG_Q_NONE, `MRG_ERR_RANGE));
      rc({2'h1, g, 4'h0}, -32'sd20000000, "offs");
      c = 20'($random(seed));
      cmd(4'h5, g, {{12{c[19]}}, c});
      rc({2'h1, g, 4'h0}, {{12{c[19]}}, c}, "offs");
      cmd(4'h6, g, `MRG_TIME_MAX);
      er(20'h0);
      rc({2'h1, g, 4'h4}, `MRG_TIME_MAX, "len");
      end_of_test;
   end
endmodule
